/* inc/srm_pkg.sv */
// Package for the SCSI repeater supervisory block: register map, fields, timing.
// Assumes a 25 MHz aclk and 32-bit AXI4-Lite register access.
package srm_pkg;

  // ***********************************************
  // Clock and timing
  // ***********************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned HEARTBEAT_MS = 500;
  localparam int unsigned FASTBLINK_MS = 50;
  localparam int unsigned GPIO_WAIT_MS = 100;
  localparam int unsigned SEL_DEBOUNCE_MS = 10;
  localparam int unsigned BUSRST_US = 25;
  localparam int unsigned HEARTBEAT_CYC = CLK_HZ / 1000 * HEARTBEAT_MS;
  localparam int unsigned FASTBLINK_CYC = CLK_HZ / 1000 * FASTBLINK_MS;
  localparam int unsigned GPIO_WAIT_CYC = CLK_HZ / 1000 * GPIO_WAIT_MS;
  localparam int unsigned SEL_DEBOUNCE_CYC = CLK_HZ / 1000 * SEL_DEBOUNCE_MS;
  localparam int unsigned BUSRST_CYC = (CLK_HZ / 1_000_000) * BUSRST_US;

  // ***********************************************
  // Register map (byte addresses)
  // ***********************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

  // CTRL fields
  localparam int unsigned CTRL_CMD_VALID_BIT = 0;
  localparam int unsigned CTRL_LUN_MODE_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // STAT fields
  localparam int unsigned ST_LUN_BIT = 0;
  localparam int unsigned ST_SEL_DIFF_BIT = 1;
  localparam int unsigned ST_EXT_EN_BIT = 2;
  localparam int unsigned ST_MISWIRE_BIT = 3;
  localparam int unsigned ST_DSFAULT_BIT = 4;
  localparam int unsigned ST_READY_BIT = 5;

  // Interrupt fields
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_SEL_CHG_BIT = 0;
  localparam int unsigned IRQ_DSFAULT_BIT = 1;
  localparam int unsigned IRQ_MODE_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    SRM_WAKE = 4'b0001,
    SRM_WAIT_CMD = 4'b0010,
    SRM_RUN = 4'b0100,
    SRM_FAULT = 4'b1000
  } srm_state_t;

endpackage : srm_pkg

/* core/srm_core.sv */
// Supervisory logic of the SCSI repeater/converter board.
// Assumes all pin inputs are asynchronous to aclk; register access over AXI4-Lite.
//
// Functional notes
// R01: Controller commands repeater or LUN mode after self test; board adopts it.
// R02: Without GPIO link at start-up, board comes up as repeater.
// R03: Controller exchanges mode commands and status only over GPIO bus.
// R04: Heartbeat LED toggles slowly while powered.
// R05: Repeater mode forwards all transactions between external and internal bus.
// R06: Differential selection converts differential host side to single-ended inside.
// R07: Light the LED beside the selected external port.
// R08: Wrong bus type on selected port flashes that LED rapidly.
// R09: Sample selector at power-up, then verify attached bus type matches.
// R10: Differential port active and DIFFSENSE low disables external bus at once.
// R11: Notify controller whenever selector position changes during operation.
// R12: Any selector change pulses internal bus reset toward the autochanger.
// R13: After DIFFSENSE fault keep external bus off until next selector evaluation.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module srm_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gpio_link_present,
  input wire logic sel_diff_pin,
  input wire logic diffsense_pin,
  input wire logic se_wrong_type_pin,
  output logic ext_bus_enable,
  output logic diff_mode,
  output logic lun_mode,
  output logic int_bus_reset,
  output logic led_se,
  output logic led_diff,
  output logic led_heartbeat,
  output logic irq
);
  import srm_pkg::*;

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  // Kept out of reset so the pin levels are already settled when wake-up samples them
  always_ff @(posedge aclk) begin
    pin_meta_reg <= {se_wrong_type_pin, diffsense_pin, sel_diff_pin, gpio_link_present};
    pin_sync_reg <= pin_meta_reg;
  end
  logic link_s, sel_s, dsense_s, se_wrong_s;
  assign link_s = pin_sync_reg[0];
  assign sel_s = pin_sync_reg[1];
  assign dsense_s = pin_sync_reg[2];
  assign se_wrong_s = pin_sync_reg[3];

  // ***********************************************
  // Selector debounce
  // ***********************************************
  // A slider bounces; only a position held for the full window is believed
  logic sel_stable_reg;
  logic sel_change;
  logic [31:0] deb_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deb_cnt_reg <= 32'h0000_0000;
    end else if (sel_s == sel_stable_reg) begin
      deb_cnt_reg <= 32'h0000_0000;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 32'h0000_0001;
    end
  end
  assign sel_change = (sel_s != sel_stable_reg) && (deb_cnt_reg >= SEL_DEBOUNCE_CYC - 1);

  // ***********************************************
  // Mode sequencer
  // ***********************************************
  srm_state_t state_reg;
  logic [31:0] wait_cnt_reg;
  logic [31:0] ctrl_reg;
  logic cmd_seen;
  assign cmd_seen = ctrl_reg[CTRL_CMD_VALID_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SRM_WAKE;
      wait_cnt_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        SRM_WAKE: begin
          wait_cnt_reg <= 32'h0000_0000;
          state_reg <= SRM_WAIT_CMD;
        end
        SRM_WAIT_CMD: begin
          wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
          if (cmd_seen) begin
            state_reg <= SRM_RUN; // R01
          end else if (!link_s || wait_cnt_reg >= GPIO_WAIT_CYC - 1) begin
            state_reg <= SRM_RUN; // R02
          end
        end
        SRM_RUN: begin
          if (sel_stable_reg && !dsense_s) begin
            state_reg <= SRM_FAULT; // R10
          end
        end
        SRM_FAULT: begin
          if (sel_change) begin
            state_reg <= SRM_RUN; // R13
          end
        end
        default: state_reg <= SRM_WAKE;
      endcase
    end
  end

  // Selector is caught at wake-up and re-evaluated after each debounced change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_stable_reg <= 1'b0;
    end else if (state_reg == SRM_WAKE) begin
      sel_stable_reg <= sel_s; // R09
    end else if (sel_change) begin
      sel_stable_reg <= ~sel_stable_reg;
    end
  end

  // Mode is latched only from a controller command; otherwise repeater
  logic lun_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lun_reg <= 1'b0;
    end else if (cmd_seen && state_reg != SRM_WAKE) begin
      lun_reg <= ctrl_reg[CTRL_LUN_MODE_BIT]; // R01 R03
    end
  end

  // ***********************************************
  // Bus path control
  // ***********************************************
  logic miswire;
  assign miswire = sel_stable_reg ? !dsense_s : se_wrong_s; // R09
  logic ext_en_reg;
  logic diff_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_reg <= 1'b0;
      diff_reg <= 1'b0;
    end else begin
      // DIFFSENSE also gates the enable directly so the bus drops on the same edge that enters SRM_FAULT, not a cycle later
      ext_en_reg <= (state_reg == SRM_RUN) && !(sel_stable_reg && !dsense_s) && !sel_change; // R05 R10 R13
      diff_reg <= sel_stable_reg; // R06
    end
  end
  assign ext_bus_enable = ext_en_reg;
  assign diff_mode = diff_reg;
  assign lun_mode = lun_reg;

  // Internal bus reset pulse on every switch change
  logic [15:0] rst_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_reg <= 16'h0000;
    end else if (sel_change && state_reg != SRM_WAKE) begin
      rst_cnt_reg <= 16'(BUSRST_CYC); // R12
    end else if (rst_cnt_reg != 16'h0000) begin
      rst_cnt_reg <= rst_cnt_reg - 16'h0001;
    end
  end
  assign int_bus_reset = (rst_cnt_reg != 16'h0000);

  // ***********************************************
  // Indicators
  // ***********************************************
  logic [31:0] hb_cnt_reg;
  logic hb_reg;
  logic [31:0] fb_cnt_reg;
  logic fb_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hb_cnt_reg <= 32'h0000_0000;
      hb_reg <= 1'b0;
    end else if (hb_cnt_reg >= HEARTBEAT_CYC - 1) begin
      hb_cnt_reg <= 32'h0000_0000;
      hb_reg <= ~hb_reg; // R04
    end else begin
      hb_cnt_reg <= hb_cnt_reg + 32'h0000_0001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_cnt_reg <= 32'h0000_0000;
      fb_reg <= 1'b0;
    end else if (fb_cnt_reg >= FASTBLINK_CYC - 1) begin
      fb_cnt_reg <= 32'h0000_0000;
      fb_reg <= ~fb_reg;
    end else begin
      fb_cnt_reg <= fb_cnt_reg + 32'h0000_0001;
    end
  end
  logic port_led;
  logic led_se_reg, led_diff_reg;
  assign port_led = (miswire || state_reg == SRM_FAULT) ? fb_reg : 1'b1; // R08
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_se_reg <= 1'b0;
      led_diff_reg <= 1'b0;
    end else begin
      led_se_reg <= !sel_stable_reg && port_led; // R07
      led_diff_reg <= sel_stable_reg && port_led; // R07
    end
  end
  assign led_se = led_se_reg;
  assign led_diff = led_diff_reg;
  assign led_heartbeat = hb_reg;

  // ***********************************************
  // Interrupt status
  // ***********************************************
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_w1c;
  logic fault_entry;
  logic mode_entry;
  assign fault_entry = (state_reg == SRM_RUN) && sel_stable_reg && !dsense_s;
  assign mode_entry = (state_reg == SRM_WAIT_CMD) && (cmd_seen || !link_s || wait_cnt_reg >= GPIO_WAIT_CYC - 1);
  assign irq_event = {mode_entry, fault_entry, sel_change && state_reg != SRM_WAKE}; // R11

  // ***********************************************
  // AXI4-Lite slave
  // ***********************************************
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic do_write;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  logic wr_ctrl, wr_mask, wr_istat, wr_known;
  assign wr_ctrl = do_write && awaddr_reg == CTRL_OFS;
  assign wr_mask = do_write && awaddr_reg == IRQ_MASK_OFS;
  assign wr_istat = do_write && awaddr_reg == IRQ_STAT_OFS;
  assign wr_known = wr_ctrl || wr_mask || wr_istat || awaddr_reg == STAT_OFS;
  assign irq_w1c = (wr_istat && wstrb_reg[0]) ? wdata_reg[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bresp_reg <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_known && awaddr_reg[7:4] == 4'h0) ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Writes to CTRL arrive from the GPIO side of the controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end else begin
      if (wr_ctrl && wstrb_reg[0]) begin
        ctrl_reg[7:0] <= wdata_reg[7:0]; // R03
      end
      if (wr_mask && wstrb_reg[0]) begin
        irq_mask_reg <= wdata_reg[IRQ_W-1:0];
      end
    end
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_event; // R11
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg); // R11

  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_LUN_BIT] = lun_reg;
    stat_word[ST_SEL_DIFF_BIT] = sel_stable_reg;
    stat_word[ST_EXT_EN_BIT] = ext_en_reg;
    stat_word[ST_MISWIRE_BIT] = miswire;
    stat_word[ST_DSFAULT_BIT] = (state_reg == SRM_FAULT);
    stat_word[ST_READY_BIT] = (state_reg == SRM_RUN) || (state_reg == SRM_FAULT);
  end

  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= AXI_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        CTRL_OFS: rdata_reg <= ctrl_reg;
        STAT_OFS: rdata_reg <= stat_word;
        IRQ_STAT_OFS: rdata_reg <= {29'h0000_0000, irq_stat_reg};
        IRQ_MASK_OFS: rdata_reg <= {29'h0000_0000, irq_mask_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= AXI_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : srm_core
`default_nettype wire

/* bench/srm_properties.sv */
// Checker: port-level timing relations of the repeater supervisory core.
// Assumes one aclk domain with synchronous active-low aresetn; bound to srm_core.
`timescale 1ns/1ns
`default_nettype none
module srm_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic diffsense_pin,
  input wire logic ext_bus_enable,
  input wire logic diff_mode,
  input wire logic lun_mode,
  input wire logic int_bus_reset,
  input wire logic led_se,
  input wire logic led_diff,
  input wire logic led_heartbeat
);
  import srm_pkg::*;
  // ********
  // Properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ds_fault;
    $fell(ext_bus_enable) && diff_mode && !diffsense_pin;
  endsequence
  // Reset itself is the cause here, so this one is never disabled
  property p_rst;
    disable iff (1'b0) !aresetn |=> !ext_bus_enable && !lun_mode && !int_bus_reset && !led_se && !led_diff;
  endproperty
  property p_bresp;
    s_wr_hs |-> ##2 s_axi_bvalid;
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rvalid;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_arref;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_led;
    led_diff |-> diff_mode && !led_se;
  endproperty
  // Pin passes a two-flop synchroniser, hence the few cycles of slack
  property p_dsense;
    diff_mode && !diffsense_pin |-> ##[1:5] !ext_bus_enable;
  endproperty
  property p_fhold;
    s_ds_fault |=> !ext_bus_enable [*8];
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_bresp: assert property (p_bresp) else $error("write response late");
  a_bhold: assert property (p_bhold) else $error("write response not held");
  a_rvalid: assert property (p_rvalid) else $error("read data late");
  a_rhold: assert property (p_rhold) else $error("read data not held");
  a_arref: assert property (p_arref) else $error("read address taken while busy");
  a_led: assert property (p_led) else $error("wrong port indicator lit");
  a_dsense: assert property (p_dsense) else $error("external bus kept on with sense low");
  a_fhold: assert property (p_fhold) else $error("external bus back on after sense fault");
  // A heartbeat level held past one half period means the board is stuck
  logic [31:0] hb_still_reg;
  logic hb_last_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hb_still_reg <= 32'h0000_0000;
    end else if (led_heartbeat != hb_last_reg) begin
      hb_still_reg <= 32'h0000_0000;
    end else begin
      hb_still_reg <= hb_still_reg + 32'h0000_0001;
    end
    hb_last_reg <= led_heartbeat;
  end
  property p_hbeat;
    hb_still_reg <= 32'(HEARTBEAT_CYC);
  endproperty
  a_hbeat: assert property (p_hbeat) else $error("heartbeat indicator stuck");
endmodule : srm_properties
bind srm_core srm_properties srm_properties_i (.*);
`default_nettype wire

/* bench/srm_far_model.sv */
// Far-side model: cable link, selector switch and attached-bus sense lines.
// Assumes the bench sets the wiring while the core is held in reset, then also changes the sense and selector lines while it runs.
`timescale 1ns/1ns
`default_nettype none
module srm_far_model (
  input wire logic link_want,
  input wire logic diff_want,
  input wire logic dsense_want,
  input wire logic wrong_want,
  output logic gpio_link_present,
  output logic sel_diff_pin,
  output logic diffsense_pin,
  output logic se_wrong_type_pin
);
  // ********
  // Wiring
  // ********
  // Static levels: switch and cables do not move with the clock
  assign gpio_link_present = link_want;
  assign sel_diff_pin = diff_want;
  assign diffsense_pin = dsense_want;
  assign se_wrong_type_pin = wrong_want;
endmodule : srm_far_model
`default_nettype wire

/* bench/srm_core_tb.sv */
// Bench for the supervisory core: register bus, start-up modes, sense fault, interrupt.
// Assumes the far-side model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module srm_core_tb;
  import srm_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic gpio_link_present, sel_diff_pin, diffsense_pin, se_wrong_type_pin;
  logic ext_bus_enable, diff_mode, lun_mode, int_bus_reset, led_se, led_diff, led_heartbeat, irq;
  logic link_want, diff_want, dsense_want, wrong_want;
  logic [1:0] wr_q[$];
  logic [65:0] rd_q[$];
  logic [65:0] e;
  logic [3:0] cfg [3];
  int errors, tests_run, seed, n, i;
  srm_core srm_core_i (.*);
  srm_far_model srm_far_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic pin(input string nm, input logic ex, input logic got);
    chk(nm, {31'h0, ex}, {31'h0, got});
  endtask : pin
  task automatic complete_run();
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // Handshakes are judged at the falling edge, where combinational readies have settled
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] x, input logic [31:0] m,
                     input logic [1:0] r);
    int k;
    logic ta, tw, tb;
    if (wr) wr_q.push_back(r);
    else rd_q.push_back({m, x & m, r});
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (k = 0; k < 100; k++) begin
      @(negedge aclk);
      ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      if (tb) s_axi_rready <= 1'b0;
      if (tb) break;
    end
    if (k == 100) begin
      errors++;
      complete_run();
    end
  endtask : bus
  task automatic wait_en(input logic v);
    for (n = 0; n < 50 && ext_bus_enable !== v; n++) @(negedge aclk);
    pin("ext_bus_enable", v, ext_bus_enable);
    if (n == 50) begin
      errors++;
      complete_run();
    end
  endtask : wait_en
  always @(negedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, wr_q.pop_front()}, {30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) begin
      e = rd_q.pop_front();
      chk("rresp", {30'h0, e[1:0]}, {30'h0, s_axi_rresp});
      chk("rdata", e[33:2], s_axi_rdata & e[65:34]);
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    seed = 94687;
    errors = 0;
    tests_run = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    {link_want, diff_want, dsense_want, wrong_want} = 4'h2;
    cfg = '{4'h2, 4'hB, 4'hE};
    for (i = 0; i < 3; i++) begin
      @(posedge aclk);
      aresetn <= 1'b0;
      {link_want, diff_want, dsense_want, wrong_want} <= cfg[i];
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (30) @(negedge aclk);
      pin("ext_bus_enable", i == 0, ext_bus_enable);
      if (i > 0) begin
        d = $random(seed);
        bus(1'b1, {24'h0, CTRL_OFS}, {d[31:2], i == 2, 1'b1}, 32'hFFFF_FFFF, AXI_OKAY);
        bus(1'b0, {24'h0, CTRL_OFS}, {24'h0, d[7:2], i == 2, 1'b1}, 32'hFFFF_FFFF, AXI_OKAY);
      end
      wait_en(1'b1);
      pin("lun_mode", i == 2, lun_mode);
      pin("int_bus_reset", 1'b0, int_bus_reset);
      pin("diff_mode", diff_want, diff_mode);
      pin("led_diff", diff_want, led_diff);
      if (i == 0) pin("led_se", 1'b1, led_se);
      bus(1'b0, {24'h0, STAT_OFS}, {27'h0, 1'b0, wrong_want, 1'b1, diff_want, i == 2}, 32'h0000_001F, AXI_OKAY);
    end
    @(posedge aclk);
    dsense_want <= 1'b0;
    wait_en(1'b0);
    @(posedge aclk);
    dsense_want <= 1'b1;
    repeat (40) @(negedge aclk);
    pin("ext_bus_enable", 1'b0, ext_bus_enable);
    pin("irq", 1'b0, irq);
    // A selector bounce shorter than the debounce window is no change
    @(posedge aclk);
    diff_want <= 1'b0;
    repeat (8) @(posedge aclk);
    diff_want <= 1'b1;
    repeat (8) @(negedge aclk);
    pin("int_bus_reset", 1'b0, int_bus_reset);
    pin("ext_bus_enable", 1'b0, ext_bus_enable);
    pin("diff_mode", 1'b1, diff_mode);
    bus(1'b0, {24'h0, STAT_OFS}, 32'h0000_0013, 32'h0000_001F, AXI_OKAY);
    bus(1'b1, {24'h0, IRQ_MASK_OFS}, 32'h0000_0002, 32'hFFFF_FFFF, AXI_OKAY);
    @(negedge aclk);
    pin("irq", 1'b1, irq);
    bus(1'b1, {24'h0, IRQ_STAT_OFS}, 32'h0000_0002, 32'hFFFF_FFFF, AXI_OKAY);
    bus(1'b0, {24'h0, IRQ_STAT_OFS}, 32'h0000_0000, 32'h0000_0003, AXI_OKAY);
    @(negedge aclk);
    pin("irq", 1'b0, irq);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000, 32'hFFFF_FFFF, AXI_SLVERR);
    bus(1'b1, 32'h0000_0014, $random(seed), 32'hFFFF_FFFF, AXI_SLVERR);
    complete_run();
  end
endmodule : srm_core_tb
`default_nettype wire
